// [src/sol_pkg.sv]
// Constants and carrier types for the status output line block
package sol_pkg;
	localparam int ADDR_W = 8;
	localparam int N_SRC = 4;
	localparam int N_CALL = 4;
	localparam int N_ALERT = 2;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] A_DLY0 = 8'h04;
	localparam logic [ADDR_W-1:0] A_DUR0 = 8'h08;
	localparam logic [ADDR_W-1:0] A_MODE0 = 8'h0c;
	localparam logic [ADDR_W-1:0] A_DLY1 = 8'h10;
	localparam logic [ADDR_W-1:0] A_DUR1 = 8'h14;
	localparam logic [ADDR_W-1:0] A_MODE1 = 8'h18;
	localparam logic [ADDR_W-1:0] A_REFL = 8'h1c;
	localparam logic [ADDR_W-1:0] A_STAT = 8'h20;
	// Control fields and reset value (all lines active high)
	localparam int EN_LSB = 0;
	localparam int POL_A_LSB = 4;
	localparam int POL_PA = 6;
	localparam int POL_INH = 7;
	localparam logic [31:0] CTRL_RST = 32'h0000_00f0;
	// Mode fields: type enables, 2-bit pattern and 2-bit priority per call type
	localparam int MODE_W = 20;
	localparam int PAT_LSB = 4;
	localparam int PRI_LSB = 12;
	localparam logic [1:0] PAT_STEADY = 2'h0;
	localparam logic [1:0] PAT_SLOW = 2'h1;
	localparam logic [1:0] PAT_FAST = 2'h2;
	localparam int SLOW_BIT = 9;
	localparam int FAST_BIT = 7;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int MS_TIME_US = 1000;
	localparam int PA_TIME_US = 2000;
	localparam int MS_CYC = MS_TIME_US * CLK_MHZ;
	localparam int PA_CYC = PA_TIME_US * CLK_MHZ;
	localparam int MS_CW = 17;
	localparam int PA_CW = 18;
	localparam int TMR_W = 16;
	typedef enum logic [1:0] {
		AL_IDLE = 2'b00,
		AL_WAIT = 2'b01,
		AL_RING = 2'b10,
		AL_DONE = 2'b11
	} sol_alert_st_t;
	// Call types: individual, priority, group, emergency
	typedef struct packed {
		logic [N_CALL-1:0] call;
		logic local_ptt;
		logic pa_mode;
		logic ptt_resolved;
		logic [N_SRC-1:0] inhibit;
	} sol_radio_t;
	typedef struct packed {
		logic [N_ALERT-1:0] alert;
		logic pa;
		logic inh;
	} sol_lines_t;
	typedef struct packed {
		sol_alert_st_t st;
		logic [TMR_W-1:0] tmr;
	} sol_alert_t;
endpackage : sol_pkg

// [src/sol_status_lines.sv]
// Status output line actions: external alerts, public address and inhibit status
`timescale 1ns/10ps
// Notes on behaviour
// - Unanswered enabled call after programmed delay drives alert line per settings.
// - Alert stops once external PTT or local PTT answers the call.
// - Alert never activates unless user enable bit is set.
// - Reset, standing for power cycle, clears user alert enables.
// - Two alert channels, each with own delay, duration and mode.
// - Mode selects ring pattern and priority per call type.
// - PA line active only in PA mode with PTT active.
// - PA activation follows resolved PTT off-to-on in PA mode.
// - PA line drops on leaving PA mode or PTT off.
// - PA changes take effect about 2 ms after the trigger.
// - Inhibit line is OR of inhibit states of reflected sources.
// - Source priority plays no part in the inhibit OR.
// - Inhibit line follows both rising and falling combined state.
// - Inhibit line follows combined state within 2 ms.
// - Each action line has a programmable active level.
// - Each PTT source has its own reflect flag.
module sol_status_lines #(
	parameter int PA_CYCLES = sol_pkg::PA_CYC,
	parameter int MS_CYCLES = sol_pkg::MS_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sol_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [sol_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_ptt_pin,
	input wire sol_pkg::sol_radio_t radio,
	output sol_pkg::sol_lines_t lines
);
	import sol_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [N_ALERT-1:0][TMR_W-1:0] dly;
		logic [N_ALERT-1:0][TMR_W-1:0] dur;
		logic [N_ALERT-1:0][MODE_W-1:0] mode;
		logic [N_SRC-1:0] refl;
		logic [MS_CW-1:0] ms_pre;
		logic [SLOW_BIT:0] ms_cnt;
		sol_alert_t [N_ALERT-1:0] ach;
		logic [N_ALERT-1:0] alert_act;
		logic pa_act;
		logic [PA_CW-1:0] pa_cnt;
		logic inh_act;
		logic ptt_s1;
		logic ptt_s2;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		sol_lines_t lines;
	} sol_state_t;

	sol_state_t s;
	sol_state_t next_s;
	logic answered;
	logic ms_tick;
	logic pa_req;

	// Address decode shared by read and write paths
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		case (a)
			A_CTRL, A_DLY0, A_DUR0, A_MODE0, A_DLY1, A_DUR1, A_MODE1, A_REFL, A_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	// Byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		wmerge = r;
	endfunction : wmerge

	// Pattern of the highest-priority pending call type
	function automatic logic [1:0] pick_pat(input logic [MODE_W-1:0] m,
		input logic [N_CALL-1:0] pend);
		logic [1:0] best;
		logic [1:0] pat;
		logic hit;
		best = 2'h0;
		pat = PAT_STEADY;
		hit = 1'b0;
		for (int t = 0; t < N_CALL; t++) begin
			if (pend[t] && (!hit || m[PRI_LSB+2*t +: 2] > best)) begin
				hit = 1'b1;
				best = m[PRI_LSB+2*t +: 2];
				pat = m[PAT_LSB+2*t +: 2];
			end
		end
		pick_pat = pat;
	endfunction : pick_pat

	// Ring pattern gate from the millisecond counter
	function automatic logic pat_on(input logic [1:0] p, input logic [SLOW_BIT:0] c);
		case (p)
			PAT_STEADY: pat_on = 1'b1;
			PAT_SLOW: pat_on = c[SLOW_BIT];
			PAT_FAST: pat_on = c[FAST_BIT];
			default: pat_on = c[SLOW_BIT] & c[FAST_BIT];
		endcase
	endfunction : pat_on

	assign answered = s.ptt_s2 | radio.local_ptt;
	assign ms_tick = (s.ms_pre == MS_CW'(MS_CYCLES - 1));
	assign pa_req = radio.pa_mode & radio.ptt_resolved;

	// Next-state logic for the whole block
	always_comb begin
		logic [N_CALL-1:0] pend;
		logic [31:0] wv;
		pend = '0;
		wv = '0;
		next_s = s;
		// Pin synchroniser for the external PTT input
		next_s.ptt_s1 = ext_ptt_pin;
		next_s.ptt_s2 = s.ptt_s1;
		// Millisecond time base
		next_s.ms_pre = ms_tick ? '0 : s.ms_pre + 1'b1;
		if (ms_tick) begin
			next_s.ms_cnt = s.ms_cnt + 1'b1;
		end
		// Alert channels, independent of each other
		for (int c = 0; c < N_ALERT; c++) begin
			pend = radio.call & s.mode[c][N_CALL-1:0];
			if (!s.ctrl[EN_LSB+c] || pend == '0) begin
				next_s.ach[c].st = AL_IDLE;
				next_s.ach[c].tmr = '0;
			end else begin
				case (s.ach[c].st)
					AL_IDLE: begin
						next_s.ach[c].st = AL_WAIT;
						next_s.ach[c].tmr = '0;
					end
					AL_WAIT: begin
						if (answered) begin
							next_s.ach[c].st = AL_DONE;
						end else if (s.ach[c].tmr >= s.dly[c]) begin
							next_s.ach[c].st = AL_RING;
							next_s.ach[c].tmr = '0;
						end else if (ms_tick) begin
							next_s.ach[c].tmr = s.ach[c].tmr + 1'b1;
						end
					end
					AL_RING: begin
						if (answered) begin
							next_s.ach[c].st = AL_DONE;
						end else if (s.dur[c] != '0 && s.ach[c].tmr >= s.dur[c]) begin
							next_s.ach[c].st = AL_DONE;
						end else if (ms_tick) begin
							next_s.ach[c].tmr = s.ach[c].tmr + 1'b1;
						end
					end
					AL_DONE: next_s.ach[c].st = AL_DONE;
					default: next_s.ach[c].st = AL_IDLE;
				endcase
			end
			next_s.alert_act[c] = (next_s.ach[c].st == AL_RING) &&
				pat_on(pick_pat(s.mode[c], pend), s.ms_cnt);
		end
		// Public address line follows request after the settle time
		if (pa_req == s.pa_act) begin
			next_s.pa_cnt = '0;
		end else if (s.pa_cnt == PA_CW'(PA_CYCLES - 1)) begin
			next_s.pa_act = pa_req;
			next_s.pa_cnt = '0;
		end else begin
			next_s.pa_cnt = s.pa_cnt + 1'b1;
		end
		// Inhibit OR over reflected sources, no priority term
		next_s.inh_act = |(radio.inhibit & s.refl);
		// Write channel: address and data taken in either order
		if (awvalid && s.awready) begin
			next_s.awready = 1'b0;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.wready = 1'b0;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = addr_ok(s.awaddr) ? RESP_OK : RESP_ERR;
			case (s.awaddr)
				A_CTRL: next_s.ctrl = wmerge(s.ctrl, s.wdata, s.wstrb);
				A_DLY0: next_s.dly[0] = TMR_W'(wmerge(32'(s.dly[0]), s.wdata, s.wstrb));
				A_DUR0: next_s.dur[0] = TMR_W'(wmerge(32'(s.dur[0]), s.wdata, s.wstrb));
				A_MODE0: next_s.mode[0] = MODE_W'(wmerge(32'(s.mode[0]), s.wdata, s.wstrb));
				A_DLY1: next_s.dly[1] = TMR_W'(wmerge(32'(s.dly[1]), s.wdata, s.wstrb));
				A_DUR1: next_s.dur[1] = TMR_W'(wmerge(32'(s.dur[1]), s.wdata, s.wstrb));
				A_MODE1: next_s.mode[1] = MODE_W'(wmerge(32'(s.mode[1]), s.wdata, s.wstrb));
				A_REFL: next_s.refl = N_SRC'(wmerge(32'(s.refl), s.wdata, s.wstrb));
				default: wv = '0;
			endcase
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		// Read channel
		if (arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = addr_ok(araddr) ? RESP_OK : RESP_ERR;
			case (araddr)
				A_CTRL: wv = s.ctrl;
				A_DLY0: wv = 32'(s.dly[0]);
				A_DUR0: wv = 32'(s.dur[0]);
				A_MODE0: wv = 32'(s.mode[0]);
				A_DLY1: wv = 32'(s.dly[1]);
				A_DUR1: wv = 32'(s.dur[1]);
				A_MODE1: wv = 32'(s.mode[1]);
				A_REFL: wv = 32'(s.refl);
				A_STAT: wv = 32'({s.ach[1].st, s.ach[0].st, s.lines, s.inh_act, s.pa_act,
					s.alert_act});
				default: wv = '0;
			endcase
			next_s.rdata = wv;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		// Output lines with programmable active level
		for (int c = 0; c < N_ALERT; c++) begin
			next_s.lines.alert[c] = next_s.alert_act[c] ~^ next_s.ctrl[POL_A_LSB+c];
		end
		next_s.lines.pa = next_s.pa_act ~^ next_s.ctrl[POL_PA];
		next_s.lines.inh = next_s.inh_act ~^ next_s.ctrl[POL_INH];
		// Synchronous reset: enables cleared, lines inactive
		if (!aresetn) begin
			next_s = '0;
			next_s.ctrl = CTRL_RST;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
			next_s.arready = 1'b1;
			for (int c = 0; c < N_ALERT; c++) begin
				next_s.lines.alert[c] = ~CTRL_RST[POL_A_LSB+c];
			end
			next_s.lines.pa = ~CTRL_RST[POL_PA];
			next_s.lines.inh = ~CTRL_RST[POL_INH];
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		s <= next_s;
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign lines = s.lines;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_alert_start;
		$rose(s.ach[0].st == AL_RING) |-> $past(s.ach[0].st) == AL_WAIT && $past(!answered);
	endproperty
	a_alert_start: assert property (p_alert_start) else $error("alert started without wait");
	property p_answer;
		answered |=> s.alert_act == '0;
	endproperty
	a_answer: assert property (p_answer) else $error("alert active after answer");
	property p_user_en;
		##1 (s.alert_act & ~$past(s.ctrl[EN_LSB +: N_ALERT])) == '0;
	endproperty
	a_user_en: assert property (p_user_en) else $error("alert without user enable");
	property p_rst_clear;
		disable iff (1'b0) !aresetn |=> s.ctrl[EN_LSB +: N_ALERT] == '0 && s.lines == '0;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset left enable or line");
	property p_pa_rise;
		$rose(s.pa_act) |-> $past(pa_req) && $past(s.pa_cnt) == PA_CW'(PA_CYCLES - 1);
	endproperty
	a_pa_rise: assert property (p_pa_rise) else $error("pa rose without settled request");
	property p_pa_fall;
		$fell(s.pa_act) |-> !$past(pa_req) && $past(s.pa_cnt) == PA_CW'(PA_CYCLES - 1);
	endproperty
	a_pa_fall: assert property (p_pa_fall) else $error("pa fell without settled drop");
	property p_pa_hold;
		(pa_req == s.pa_act) [*2] |=> $stable(s.pa_act);
	endproperty
	a_pa_hold: assert property (p_pa_hold) else $error("pa changed with no trigger");
	property p_inh;
		##1 s.inh_act == $past(|(radio.inhibit & s.refl));
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit line not the masked OR");
	property p_pol;
		$changed(s.ctrl[POL_INH]) && $stable(s.inh_act) |-> $changed(s.lines.inh);
	endproperty
	a_pol: assert property (p_pol) else $error("inhibit level ignored polarity");

	c_alert: cover property ($rose(s.alert_act[0]));
	c_pa: cover property ($rose(s.pa_act));
	c_inh: cover property ($fell(s.inh_act));
	c_write: cover property (s.bvalid && bready && s.bresp == RESP_OK);
endmodule : sol_status_lines

// [verif/sol_indicator.sv]
// Far-side model: lamp, relay and accessory board reading the status lines
`timescale 1ns/10ps
module sol_indicator (
	input wire sol_pkg::sol_lines_t lines,
	input wire logic [2:0] act_high,
	output logic [3:0] on
);
	import sol_pkg::*;
	// Alert lamps and inhibit lamp decode the configured active level
	assign on[1:0] = ~(lines.alert ^ act_high[1:0]);
	assign on[3] = ~(lines.inh ^ act_high[2]);
	// Accessory board line is wired active high
	assign on[2] = lines.pa;
endmodule : sol_indicator

// [verif/sol_status_lines_test.sv]
// Self-checking bench for the status output line block
`timescale 1ns/10ps
module sol_status_lines_test;
	import sol_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic [3:0] wstrb = 4'hf, on;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, ext_ptt_pin = 0;
	sol_radio_t radio = '0;
	sol_lines_t lines;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	logic [8:0] rows [6] = '{9'h1e0, 9'h023, 9'h1c2, 9'h08d, 9'h111, 9'h10e};
	sol_status_lines #(.PA_CYCLES(8), .MS_CYCLES(4)) u_sol_status_lines (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_ptt_pin(ext_ptt_pin), .radio(radio), .lines(lines));
	sol_indicator u_sol_indicator (.lines(lines), .act_high(3'h7), .on(on));
	// Clock and hang guard
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb, fin;
		fin = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!fin) begin
			@(negedge aclk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid & bready;
			if (hb) rs = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 0;
			if (hw) wvalid <= 0;
			if (hb) bready <= 0;
			fin = hb;
		end
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		logic ha, hr, fin;
		fin = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!fin) begin
			@(negedge aclk);
			ha = arvalid & arready;
			hr = rvalid & rready;
			if (hr) rd = rdata;
			if (hr) rs = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 0;
			if (hr) rready <= 0;
			fin = hr;
		end
	endtask : rdr
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk("lines", lines, 0);
		rdr(A_CTRL);
		chk("ctrl", rd, CTRL_RST);
		rdr(8'h40);
		chk("rresp", rs, RESP_ERR);
		wr(8'h44, 32'h1);
		chk("bresp", rs, RESP_ERR);
		$display("test reset and bus done");
		// Inhibit rows: reflect flags, inhibit states, expected line
		foreach (rows[i]) begin
			wr(A_REFL, {28'h0, rows[i][8:5]});
			radio.inhibit <= rows[i][4:1];
			repeat (3) @(posedge aclk);
			chk("inh", lines.inh, rows[i][0]);
			chk("inh lamp", on[3], rows[i][0]);
		end
		rdr(A_REFL);
		chk("refl", rd, 32'h8);
		$display("test inhibit done");
		// Public address: both edges take the PA_CYCLES settle time
		radio.pa_mode <= 1;
		radio.ptt_resolved <= 1;
		repeat (4) @(posedge aclk);
		chk("pa early", lines.pa, 0);
		repeat (8) @(posedge aclk);
		chk("pa on", on[2], 1);
		radio.pa_mode <= 0;
		repeat (4) @(posedge aclk);
		chk("pa hold", lines.pa, 1);
		repeat (8) @(posedge aclk);
		chk("pa off", lines.pa, 0);
		// Mode without a PTT, then PTT on and off inside the mode
		radio.pa_mode <= 1;
		radio.ptt_resolved <= 0;
		repeat (12) @(posedge aclk);
		chk("pa no ptt", lines.pa, 0);
		radio.ptt_resolved <= 1;
		repeat (12) @(posedge aclk);
		chk("pa again", lines.pa, 1);
		radio.ptt_resolved <= 0;
		repeat (12) @(posedge aclk);
		chk("pa ptt off", lines.pa, 0);
		radio.pa_mode <= 0;
		$display("test public address done");
		// Inhibit line driven active low
		wr(A_CTRL, 32'h70);
		@(posedge aclk);
		chk("inh low", lines.inh, 1);
		$display("test polarity done");
		// Alert on channel 0 only
		radio.call <= 4'h1;
		wr(A_MODE0, 32'h1);
		chk("bresp ok", rs, RESP_OK);
		wr(A_DLY0, 32'h1);
		wr(A_DUR0, 32'h0);
		wr(A_CTRL, 32'hf0);
		repeat (20) @(posedge aclk);
		chk("no enable", lines.alert, 2'h0);
		wr(A_CTRL, 32'hf1);
		repeat (20) @(posedge aclk);
		chk("ringing", on[1:0], 2'h1);
		ext_ptt_pin <= 1;
		repeat (5) @(posedge aclk);
		chk("answered", lines.alert, 2'h0);
		ext_ptt_pin <= 0;
		// Power cycle drops the user enable
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rdr(A_CTRL);
		chk("ctrl again", rd, CTRL_RST);
		repeat (20) @(posedge aclk);
		chk("alert off", lines.alert, 2'h0);
		// Channel 1: group call (priority 3, slow) beats priority call (priority 1, steady)
		wr(A_MODE1, 32'h0003_4106);
		wr(A_CTRL, 32'hf2);
		radio.call <= 4'h6;
		repeat (8) @(posedge aclk);
		chk("slow wins", lines.alert, 2'h0);
		radio.call <= 4'h2;
		repeat (8) @(posedge aclk);
		chk("steady", on[1:0], 2'h2);
		rdr(A_STAT);
		chk("status", rd, 32'h882);
		radio.local_ptt <= 1;
		repeat (3) @(posedge aclk);
		chk("local answer", lines.alert, 2'h0);
		radio.local_ptt <= 0;
		radio.call <= 4'h0;
		// Ring limited to a 2 ms duration
		wr(A_DUR1, 32'h2);
		radio.call <= 4'h2;
		repeat (4) @(posedge aclk);
		chk("dur ring", lines.alert[1], 1'b1);
		repeat (16) @(posedge aclk);
		chk("dur end", lines.alert[1], 1'b0);
		$display("test alert done");
		end_of_test();
	end
endmodule : sol_status_lines_test
